// ===== hpbp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module hpbp_chk
    import hpbp_pkg::*;
#(
    parameter int         ADDR_W        = 5,
    parameter logic [4:0] INT_CODE_ADDR = 5'h00
) (
    input wire logic              clk_sys_i,
    input wire logic              rst_i,
    input wire logic              mode_i,
    input wire logic              register_select_n_i,
    input wire logic              rd_n_rw_i,
    input wire logic              high_byte_enable_n_i,
    input wire hpbp_bus_word_t    host_bus_i,
    input wire hpbp_bus_word_t    host_bus_o,
    input wire logic [1:0]        host_bus_oe_o,
    input wire logic              int_o,
    input wire logic              reg_rd_o,
    input wire logic              reg_wr_o,
    input wire logic [ADDR_W-1:0] reg_addr_o,
    input wire logic [1:0]        reg_lanes_o,
    input wire hpbp_bus_word_t    dma_bus_o,
    input wire logic [1:0]        dma_bus_oe_o,
    input wire logic              irq_event_i,
    input wire logic              command_issued_i,
    input wire logic              controller_busy_flag_i
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    rd_pulse_a: assert property (reg_rd_o |=> !reg_rd_o) else $error("read pulse long");
    wr_select_a: assert property (reg_wr_o |-> $past(!register_select_n_i)) else $error("write unselected");
    rw_dir_a: assert property (reg_wr_o && !$past(mode_i) |-> !$past(rd_n_rw_i)) else $error("write on read");
    upper_lane_a: assert property (reg_rd_o || reg_wr_o |-> reg_lanes_o[1] == !$past(high_byte_enable_n_i))
        else $error("upper lane wrong");
    read_oe_a: assert property (reg_rd_o |-> host_bus_oe_o == reg_lanes_o) else $error("read enable wrong");
    read_par_a: assert property (reg_rd_o && host_bus_oe_o[0] |-> ^{host_bus_o.lower, host_bus_o.lower_par})
        else $error("read parity even");
    pass_wr_a: assert property (dma_bus_oe_o[0] |-> $past(register_select_n_i)
        && dma_bus_o.lower == $past(host_bus_i.lower)) else $error("pass data wrong");
    int_mask_a: assert property ($past(controller_busy_flag_i) |-> int_o == !$past(mode_i))
        else $error("irq while busy");
    int_set_a: assert property (irq_event_i && !controller_busy_flag_i |=> int_o == $past(mode_i))
        else $error("irq not raised");
    cmd_clear_a: assert property (command_issued_i && !irq_event_i |=> int_o == !$past(mode_i))
        else $error("irq kept after command");
    code_clear_a: assert property (reg_rd_o && reg_addr_o == INT_CODE_ADDR && !$past(irq_event_i)
        |-> int_o == !$past(mode_i)) else $error("irq kept after code read");
    cover property (reg_rd_o);
    cover property (reg_wr_o);
    cover property (dma_bus_oe_o[0]);
    cover property (int_o == mode_i);
endmodule : hpbp_chk
bind hpbp_host_port hpbp_chk #(.ADDR_W(ADDR_W), .INT_CODE_ADDR(INT_CODE_ADDR)) hpbp_chk_inst (.*);
`default_nettype wire

// ===== hpbp_defs.svh
`ifndef HPBP_DEFS_SVH
`define HPBP_DEFS_SVH

// host data bus layout
`define HPBP_DATA_W        16
`define HPBP_UPPER_MSB     15
`define HPBP_UPPER_LSB     8
`define HPBP_LOWER_MSB     7
`define HPBP_LOWER_LSB     0
`define HPBP_ADDR_W        5

// byte lane enable positions
`define HPBP_LANE_UPPER    1
`define HPBP_LANE_LOWER    0

// register address read to fetch the first interrupt code (arbitrary default)
`define HPBP_INT_CODE_ADDR 5'h00

// shortest reset the controller accepts, in clock cycles
`define HPBP_RESET_MIN_CYC 4

`endif

// ===== hpbp_host_mdl.sv
`timescale 1ns/1ps
`default_nettype none
module hpbp_host_mdl
    import hpbp_pkg::*;
(
    input  wire logic           clk_sys_i,
    input  wire logic           mode_i,
    input  wire hpbp_bus_word_t host_bus_o,
    input  wire hpbp_bus_word_t dma_bus_o,
    output logic                register_select_n_i,
    output logic                dma_passthrough_select_n_i,
    output logic [4:0]          register_addr_i,
    output logic                rd_n_rw_i,
    output logic                wr_n_low_byte_strobe_n_i,
    output logic                high_byte_enable_n_i,
    output hpbp_bus_word_t      drv_o
);
    initial begin
        {register_select_n_i, dma_passthrough_select_n_i, rd_n_rw_i} = 3'h7;
        {wr_n_low_byte_strobe_n_i, high_byte_enable_n_i} = 2'h3;
        register_addr_i = 5'h00;
        drv_o = '0;
    end
    // request held three cycles, then released with one idle cycle
    task automatic access(input logic p, input logic w, input logic [4:0] a, input logic [1:0] ln,
                          input hpbp_bus_word_t d, output hpbp_bus_word_t rd, output hpbp_bus_word_t dq);
        @(posedge clk_sys_i);
        register_select_n_i <= p;
        dma_passthrough_select_n_i <= !p;
        register_addr_i <= a;
        rd_n_rw_i <= mode_i ? w : !w;
        wr_n_low_byte_strobe_n_i <= mode_i ? !w : !ln[0];
        high_byte_enable_n_i <= !ln[1];
        if (w) drv_o <= d;
        repeat (3) @(posedge clk_sys_i);
        rd = host_bus_o;
        dq = dma_bus_o;
        {register_select_n_i, dma_passthrough_select_n_i, rd_n_rw_i} <= 3'h7;
        {wr_n_low_byte_strobe_n_i, high_byte_enable_n_i} <= 2'h3;
        drv_o <= ~drv_o;
        @(posedge clk_sys_i);
    endtask : access
endmodule : hpbp_host_mdl
`default_nettype wire

// ===== hpbp_host_port.sv
// What this block does
// - register select low opens register access
// - passthrough select links host and DMA bus
// - sixteen data bits, parity per byte
// - five address bits pick the register
// - strobe style: read strobe drives register data
// - read/write style: high reads, low writes
// - strobe style: write strobe stores host data
// - read/write style: low strobe marks lower byte
// - upper enable qualifies upper byte transfers
// - interrupt high in strobe style, else low
// - interrupt held inactive while controller busy
// - command or busy start clears interrupt
// - first interrupt code read clears interrupt
`include "hpbp_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module hpbp_host_port
    import hpbp_pkg::*;
#(
    parameter int          DATA_W        = `HPBP_DATA_W,
    parameter int          ADDR_W        = `HPBP_ADDR_W,
    parameter logic [4:0]  INT_CODE_ADDR = `HPBP_INT_CODE_ADDR
) (
    input  wire logic                clk_sys_i,
    input  wire logic                rst_i,
    // host pins
    input  wire logic                mode_i,
    input  wire logic                register_select_n_i,
    input  wire logic                dma_passthrough_select_n_i,
    input  wire logic [ADDR_W-1:0]   register_addr_i,
    input  wire logic                rd_n_rw_i,
    input  wire logic                wr_n_low_byte_strobe_n_i,
    input  wire logic                high_byte_enable_n_i,
    input  wire hpbp_bus_word_t      host_bus_i,
    output var  hpbp_bus_word_t      host_bus_o,
    output logic [1:0]               host_bus_oe_o,
    output logic                     int_o,
    // register file side
    output logic                     reg_rd_o,
    output logic                     reg_wr_o,
    output logic [ADDR_W-1:0]        reg_addr_o,
    output logic [DATA_W-1:0]        reg_wdata_o,
    output logic [1:0]               reg_lanes_o,
    input  wire logic [DATA_W-1:0]   reg_rdata_i,
    // DMA data bus side
    input  wire hpbp_bus_word_t      dma_bus_i,
    output var  hpbp_bus_word_t      dma_bus_o,
    output logic [1:0]               dma_bus_oe_o,
    // controller events
    input  wire logic                irq_event_i,
    input  wire logic                command_issued_i,
    input  wire logic                controller_busy_flag_i
);

    // refuse widths that the pin decode and parity logic cannot serve
    if (DATA_W != `HPBP_DATA_W) begin : g_bad_data_w
        $error("host port data width must be 16");
    end
    if (ADDR_W != `HPBP_ADDR_W) begin : g_bad_addr_w
        $error("host port address width must be 5");
    end
    if ($bits(INT_CODE_ADDR) != ADDR_W) begin : g_bad_code_addr
        $error("interrupt code address must match the address width");
    end

    // interrupt pin level: active high in strobe style, active low otherwise
    function automatic logic int_level(input logic style, input logic active);
        int_level = style ? active : ~active;
    endfunction : int_level

    function automatic logic odd_parity(input logic [7:0] b);
        odd_parity = ~(^b);
    endfunction : odd_parity

    function automatic hpbp_bus_word_t pack_word(input logic [DATA_W-1:0] d);
        hpbp_bus_word_t w;
        w.upper     = d[`HPBP_UPPER_MSB:`HPBP_UPPER_LSB];
        w.upper_par = odd_parity(d[`HPBP_UPPER_MSB:`HPBP_UPPER_LSB]);
        w.lower     = d[`HPBP_LOWER_MSB:`HPBP_LOWER_LSB];
        w.lower_par = odd_parity(d[`HPBP_LOWER_MSB:`HPBP_LOWER_LSB]);
        pack_word   = w;
    endfunction : pack_word

    // pin decode for both bus styles
    hpbp_req_t   req;
    logic        strobe_style;
    logic        any_strobe;
    logic        reg_sel;
    logic        pass_sel;

    assign strobe_style = mode_i;
    assign reg_sel      = ~register_select_n_i;
    // both selects low: the register access wins, the passthrough is ignored
    assign pass_sel     = ~dma_passthrough_select_n_i & ~reg_sel;
    assign any_strobe   = ~wr_n_low_byte_strobe_n_i | ~high_byte_enable_n_i;

    always_comb begin
        req = '0;
        req.lanes[`HPBP_LANE_UPPER] = ~high_byte_enable_n_i;
        if (strobe_style) begin
            req.rd = ~rd_n_rw_i;
            req.wr = ~wr_n_low_byte_strobe_n_i;
            req.lanes[`HPBP_LANE_LOWER] = 1'b1;
        end else begin
            req.rd = any_strobe & rd_n_rw_i;
            req.wr = any_strobe & ~rd_n_rw_i;
            req.lanes[`HPBP_LANE_LOWER] = ~wr_n_low_byte_strobe_n_i;
        end
    end

    // access sequencer
    hpbp_state_t state_q;
    hpbp_state_t state_d;
    logic        req_live;

    // an access ends as soon as its select, strobe or direction is seen gone
    assign req_live = (state_q == HPBP_REG_RD  && reg_sel  && req.rd) ||
                      (state_q == HPBP_REG_WR  && reg_sel  && req.wr) ||
                      (state_q == HPBP_PASS_RD && pass_sel && req.rd) ||
                      (state_q == HPBP_PASS_WR && pass_sel && req.wr);

    always_comb begin
        state_d = state_q;
        case (state_q)
            HPBP_IDLE: begin
                if (reg_sel && req.rd) begin
                    state_d = HPBP_REG_RD;
                end else if (reg_sel && req.wr) begin
                    state_d = HPBP_REG_WR;
                end else if (pass_sel && req.rd) begin
                    state_d = HPBP_PASS_RD;
                end else if (pass_sel && req.wr) begin
                    state_d = HPBP_PASS_WR;
                end
            end
            HPBP_REG_RD,
            HPBP_REG_WR,
            HPBP_PASS_RD,
            HPBP_PASS_WR: begin
                if (!req_live) begin
                    state_d = HPBP_IDLE;
                end
            end
            default: begin
                state_d = HPBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_q <= HPBP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    logic reg_rd_start;
    logic reg_wr_start;

    // accesses start only from idle, so a strobe held for many cycles is taken once
    assign reg_rd_start = (state_q == HPBP_IDLE) && (state_d == HPBP_REG_RD);
    assign reg_wr_start = (state_q == HPBP_IDLE) && (state_d == HPBP_REG_WR);

    // register file strobes, one pulse per access
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reg_rd_o <= 1'b0;
            reg_wr_o <= 1'b0;
        end else begin
            reg_rd_o <= reg_rd_start;
            reg_wr_o <= reg_wr_start;
        end
    end

    // address, lanes and write data stand until the next register access starts
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reg_addr_o  <= '0;
            reg_wdata_o <= '0;
            reg_lanes_o <= '0;
        end else if (reg_rd_start || reg_wr_start) begin
            reg_addr_o  <= register_addr_i;
            reg_lanes_o <= req.lanes;
            reg_wdata_o <= {host_bus_i.upper, host_bus_i.lower};
        end
    end

    // host data pins: register read data or DMA bus data
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            host_bus_o <= '0;
        end else begin
            case (state_d)
                HPBP_REG_RD: begin
                    host_bus_o <= pack_word(reg_rdata_i);
                end
                HPBP_PASS_RD: begin
                    host_bus_o <= dma_bus_i;
                end
                default: begin
                    host_bus_o <= host_bus_o;
                end
            endcase
        end
    end

    // host pins are driven only while a read stands
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            host_bus_oe_o <= '0;
        end else if (state_d == HPBP_REG_RD || state_d == HPBP_PASS_RD) begin
            host_bus_oe_o <= req.lanes;
        end else begin
            host_bus_oe_o <= '0;
        end
    end

    // DMA data pins follow the host pins during a passthrough write
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            dma_bus_o <= '0;
        end else if (state_d == HPBP_PASS_WR) begin
            dma_bus_o <= host_bus_i;
        end
    end

    // DMA data pins driven only during a passthrough write
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            dma_bus_oe_o <= '0;
        end else if (state_d == HPBP_PASS_WR) begin
            dma_bus_oe_o <= req.lanes;
        end else begin
            dma_bus_oe_o <= '0;
        end
    end

    // interrupt request
    logic busy_q;
    logic irq_q;
    logic irq_d;
    logic irq_clr;
    logic code_read;
    logic busy_rise;
    logic irq_live;

    // any read start of the code address counts as reading the first code
    assign code_read = reg_rd_start && (register_addr_i == INT_CODE_ADDR);
    assign busy_rise = controller_busy_flag_i & ~busy_q;
    assign irq_clr   = command_issued_i
                     | busy_rise
                     | code_read;
    // a new event in the clearing cycle survives
    assign irq_d     = irq_event_i | (irq_q & ~irq_clr);
    assign irq_live  = irq_d & ~controller_busy_flag_i;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= controller_busy_flag_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // polarity follows the bus style
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            int_o <= int_level(mode_i, 1'b0);
        end else begin
            int_o <= int_level(strobe_style, irq_live);
        end
    end

endmodule : hpbp_host_port

`default_nettype wire

// ===== hpbp_pkg.sv
`default_nettype none

package hpbp_pkg;

    // one parallel bus word with a parity bit per byte
    typedef struct packed {
        logic [7:0] upper;
        logic       upper_par;
        logic [7:0] lower;
        logic       lower_par;
    } hpbp_bus_word_t;

    // request seen on the host pins in one cycle
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [1:0] lanes;
    } hpbp_req_t;

    typedef enum logic [2:0] {
        HPBP_IDLE,
        HPBP_REG_RD,
        HPBP_REG_WR,
        HPBP_PASS_RD,
        HPBP_PASS_WR
    } hpbp_state_t;

endpackage : hpbp_pkg

`default_nettype wire

// ===== tb.sv
`include "hpbp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb
    import hpbp_pkg::*;
;
    typedef struct packed {logic m; logic w; logic [4:0] a; logic [1:0] ln; logic [15:0] d;} hpbp_row_t;
    logic clk_sys_i, rst_i, mode_i, irq_event_i, command_issued_i, controller_busy_flag_i, int_o, reg_rd_o, reg_wr_o;
    logic register_select_n_i, dma_passthrough_select_n_i, rd_n_rw_i, wr_n_low_byte_strobe_n_i, high_byte_enable_n_i;
    logic [4:0]  register_addr_i, reg_addr_o;
    logic [15:0] reg_rdata_i, reg_wdata_o;
    logic [17:0] lm;
    logic [1:0]  host_bus_oe_o, reg_lanes_o, dma_bus_oe_o;
    hpbp_bus_word_t host_bus_i, host_bus_o, dma_bus_i, dma_bus_o, drv, rd, dq, ex;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_rd = 0;
    int n_wr = 0;
    always @(posedge clk_sys_i) begin
        if (reg_rd_o === 1'b1) n_rd++;
        if (reg_wr_o === 1'b1) n_wr++;
    end
    hpbp_row_t rows [6] = '{{1'b1, 1'b0, 5'h05, 2'h3, 16'ha55a}, {1'b1, 1'b0, 5'h1f, 2'h1, 16'h1234},
        {1'b1, 1'b1, 5'h0a, 2'h3, 16'hc3c3}, {1'b0, 1'b0, 5'h03, 2'h2, 16'h8001},
        {1'b0, 1'b1, 5'h11, 2'h1, 16'h00ff}, {1'b0, 1'b1, 5'h1e, 2'h3, 16'h7e81}};
    assign host_bus_i = {host_bus_oe_o[1] ? host_bus_o[17:9] : drv[17:9], host_bus_oe_o[0] ? host_bus_o[8:0] : drv[8:0]};
    hpbp_host_port hpbp_host_port_inst (.*);
    hpbp_host_mdl hpbp_host_mdl_inst (.drv_o(drv), .*);
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    task automatic ev(input logic [2:0] k);
        @(posedge clk_sys_i);
        {controller_busy_flag_i, command_issued_i, irq_event_i} <= k;
        @(posedge clk_sys_i);
        {controller_busy_flag_i, command_issued_i, irq_event_i} <= 3'h0;
        @(posedge clk_sys_i);
        #1;
    endtask : ev
    initial begin
        repeat (4000) @(posedge clk_sys_i);
        n_mismatch++;
        test_done();
    end
    initial begin
        {rst_i, mode_i, irq_event_i, command_issued_i, controller_busy_flag_i} = 5'h18;
        reg_rdata_i = 16'h0000;
        dma_bus_i = '0;
        repeat (16) @(posedge clk_sys_i);
        #1;
        `CHK(host_bus_oe_o, 2'h0)
        `CHK(int_o, 1'b0)
        @(posedge clk_sys_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            @(posedge clk_sys_i);
            mode_i <= rows[i].m;
            reg_rdata_i <= rows[i].d;
            ex = {rows[i].d[15:8], ~^rows[i].d[15:8], rows[i].d[7:0], ~^rows[i].d[7:0]};
            lm = {{9{rows[i].ln[1]}}, {9{rows[i].ln[0] | rows[i].m}}};
            hpbp_host_mdl_inst.access(1'b0, rows[i].w, rows[i].a, rows[i].ln, ex, rd, dq);
            #1;
            `CHK(reg_addr_o, rows[i].a)
            `CHK(reg_lanes_o, {rows[i].ln[1], rows[i].ln[0] | rows[i].m})
            if (rows[i].w) `CHK(reg_wdata_o, rows[i].d) else `CHK(rd & lm, ex & lm)
        end
        @(posedge clk_sys_i);
        mode_i <= 1'b1;
        dma_bus_i <= 18'h2b4c7;
        hpbp_host_mdl_inst.access(1'b1, 1'b0, 5'h00, 2'h3, '0, rd, dq);
        `CHK(rd, 18'h2b4c7)
        hpbp_host_mdl_inst.access(1'b1, 1'b1, 5'h00, 2'h3, 18'h1d2e9, rd, dq);
        `CHK(dq, 18'h1d2e9)
        for (int m = 1; m >= 0; m--) begin
            @(posedge clk_sys_i);
            mode_i <= m[0];
            ev(3'h1);
            `CHK(int_o, m[0])
            ev(3'h4);
            `CHK(int_o, !m[0])
            ev(3'h1);
            ev(3'h2);
            `CHK(int_o, !m[0])
            ev(3'h1);
            `CHK(int_o, m[0])
            hpbp_host_mdl_inst.access(1'b0, 1'b0, `HPBP_INT_CODE_ADDR, 2'h3, '0, rd, dq);
            #1;
            `CHK(int_o, !m[0])
        end
        `CHK(n_rd, 5)
        `CHK(n_wr, 3)
        test_done();
    end
endmodule : tb
`default_nettype wire
